// >>> verilog/wcp_watchdog_ctrl.v
// watchdog control register with timed change protection, apb slave
`timescale 1ns/1ps
`default_nettype none
`include "wcp_defs.vh"

module wcp_watchdog_ctrl
(
  // clock and reset
  input  wire        ref_clk,
  input  wire        reset_n,
  // apb slave
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  // configuration and watchdog side
  input  wire        safetyLevel2,
  input  wire        oscTick,
  output reg         watchdogReset,
  output reg         irq
);

  // --------------------------------------------------------------------
  // state
  // --------------------------------------------------------------------
  reg        levelTwoReg;
  reg        levelCapturedReg;
  reg        enableReg;
  reg        irqEnableReg;
  reg        chgEnableReg;
  reg [2:0]  windowReg;
  reg [3:0]  selReg;
  reg        resetFlagReg;
  reg        toIrqFlagReg;
  reg [2:0]  evStatReg;
  reg [2:0]  evEnReg;
  reg [3:0]  rstPulseReg;

  // decoded bus terms and combinational helpers
  wire       wrStrobe;
  wire       rdStrobe;
  wire       expired;
  wire       effEnable;
  wire       running;
  wire       kick;
  wire [3:0] wrSel;
  wire       wrEn;
  wire       wrChg;
  wire       wrIrqEn;
  wire       unlocked;
  wire       ctrlWrite;
  wire       toIrqEv;
  wire       toRstEv;
  reg        refusedEv;
  reg [2:0]  evSet;
  reg [2:0]  evClr;
  reg [31:0] rdValue;
  reg        addrOk;

  // apb access phase, single-wait answer through registered pready
  assign wrStrobe  = psel && penable && pwrite && !pready;
  assign rdStrobe  = psel && penable && !pwrite && !pready;
  assign ctrlWrite = wrStrobe && (paddr == `WCP_CTRL_OFS);
  assign kick      = wrStrobe && (paddr == `WCP_KICK_OFS);

  // written control fields
  assign wrSel   = {pwdata[`WCP_SEL3_BIT], pwdata[`WCP_SEL2_BIT],
                    pwdata[`WCP_SEL1_BIT], pwdata[`WCP_SEL0_BIT]};
  assign wrEn    = pwdata[`WCP_EN_BIT];
  assign wrChg   = pwdata[`WCP_CHG_BIT];
  assign wrIrqEn = pwdata[`WCP_IRQEN_BIT];
  assign unlocked = chgEnableReg && !wrChg;

  // level 2 reads enable as one; level 1 enable overridden by reset flag
  assign effEnable = levelTwoReg | enableReg | resetFlagReg;
  assign running   = effEnable | irqEnableReg;

  // --------------------------------------------------------------------
  // timeout counter
  // --------------------------------------------------------------------
  wcp_timeout_counter u_counter
  (
    .ref_clk   (ref_clk),
    .reset_n   (reset_n),
    .run       (running),
    .kick      (kick),
    .periodSel (selReg),
    .oscTick   (oscTick),
    .expired   (expired)
  );

  // timeout action: interrupt if enabled, else reset
  assign toIrqEv = expired && irqEnableReg;
  assign toRstEv = expired && !irqEnableReg && effEnable;

  // --------------------------------------------------------------------
  // safety level capture and control register
  // --------------------------------------------------------------------
  // level latched once after reset release
  always @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      levelTwoReg      <= 1'b0;
      levelCapturedReg <= 1'b0;
    end
    else if (!levelCapturedReg)
    begin
      levelTwoReg      <= safetyLevel2;
      levelCapturedReg <= 1'b1;
    end
  end

  // refused change detection
  always @*
  begin
    refusedEv = 1'b0;
    if (ctrlWrite && !unlocked && !wrChg)
    begin
      if (levelTwoReg && (wrSel != selReg))
        refusedEv = 1'b1;
      if (!levelTwoReg && enableReg && !wrEn)
        refusedEv = 1'b1;
    end
  end

  // control fields, change window
  always @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      enableReg    <= 1'b0;
      irqEnableReg <= 1'b0;
      chgEnableReg <= 1'b0;
      windowReg    <= 3'h0;
      selReg       <= `WCP_SEL_RST;
    end
    else
    begin
      // window closes by itself
      if (chgEnableReg)
      begin
        if (windowReg == 3'h1)
          chgEnableReg <= 1'b0;
        windowReg <= windowReg - 3'h1;
      end
      // interrupt enable auto-cleared on timeout when enable set
      if (toIrqEv && effEnable)
        irqEnableReg <= 1'b0;
      // software write; a fresh opening write restarts the window
      if (ctrlWrite)
      begin
        irqEnableReg <= wrIrqEn;
        if (wrChg && wrEn)
        begin
          chgEnableReg <= 1'b1;
          windowReg    <= `WCP_WIN_CYCLES;
          enableReg    <= 1'b1;
        end
        else if (unlocked)
        begin
          chgEnableReg <= 1'b0;
          windowReg    <= 3'h0;
          selReg       <= wrSel;
          if (!levelTwoReg)
            enableReg <= wrEn;
        end
        else
        begin
          if (!levelTwoReg && wrEn)
            enableReg <= 1'b1;
          if (!levelTwoReg)
            selReg <= wrSel;
        end
      end
    end
  end

  // --------------------------------------------------------------------
  // reset flag, reset pulse, events
  // --------------------------------------------------------------------
  // event set terms and write-one-to-clear terms
  always @*
  begin
    evSet = 3'h0;
    evSet[`WCP_EV_TO_IRQ]  = toIrqEv;
    evSet[`WCP_EV_TO_RST]  = toRstEv;
    evSet[`WCP_EV_REFUSED] = refusedEv;
    evClr = 3'h0;
    if (wrStrobe && (paddr == `WCP_IRQ_CLR_OFS))
      evClr = pwdata[2:0];
  end

  // sticky status, enables, reset flag and registered outputs
  always @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      resetFlagReg  <= 1'b0;
      toIrqFlagReg  <= 1'b0;
      evStatReg     <= `WCP_EV_RST;
      evEnReg       <= `WCP_EV_RST;
      rstPulseReg   <= 4'h0;
      watchdogReset <= 1'b0;
      irq           <= 1'b0;
    end
    else
    begin
      // set wins over clear
      evStatReg <= (evStatReg & ~evClr) | evSet;
      if (wrStrobe && (paddr == `WCP_IRQ_EN_OFS))
        evEnReg <= pwdata[2:0];
      // reset flag: set on timeout reset, cleared by writing zero
      if (toRstEv)
        resetFlagReg <= 1'b1;
      else if (wrStrobe && (paddr == `WCP_FLAG_OFS) && !pwdata[0])
        resetFlagReg <= 1'b0;
      if (toIrqEv)
        toIrqFlagReg <= 1'b1;
      else if (ctrlWrite && pwdata[`WCP_TOIRQ_BIT])
        toIrqFlagReg <= 1'b0;
      // reset output stretched over several cycles
      if (toRstEv)
        rstPulseReg <= `WCP_RST_PULSE;
      else if (rstPulseReg != 4'h0)
        rstPulseReg <= rstPulseReg - 4'h1;
      watchdogReset <= toRstEv || (rstPulseReg > 4'h1);
      irq <= |(((evStatReg & ~evClr) | evSet) & evEnReg);
    end
  end

  // --------------------------------------------------------------------
  // apb read and answer
  // --------------------------------------------------------------------
  // read mux; unmapped offsets read zero and answer with an error
  always @*
  begin
    rdValue = 32'h00000000;
    addrOk  = 1'b1;
    case (paddr)
      `WCP_CTRL_OFS:
      begin
        rdValue[`WCP_SEL0_BIT]  = selReg[0];
        rdValue[`WCP_SEL1_BIT]  = selReg[1];
        rdValue[`WCP_SEL2_BIT]  = selReg[2];
        rdValue[`WCP_SEL3_BIT]  = selReg[3];
        rdValue[`WCP_EN_BIT]    = effEnable;
        rdValue[`WCP_CHG_BIT]   = chgEnableReg;
        rdValue[`WCP_IRQEN_BIT] = irqEnableReg;
        rdValue[`WCP_TOIRQ_BIT] = toIrqFlagReg;
      end
      `WCP_STAT_OFS:     rdValue[2:0] = {levelTwoReg, running, resetFlagReg};
      `WCP_IRQ_STAT_OFS: rdValue[2:0] = evStatReg;
      `WCP_IRQ_EN_OFS:   rdValue[2:0] = evEnReg;
      `WCP_IRQ_CLR_OFS:  rdValue = 32'h00000000;
      `WCP_FLAG_OFS:     rdValue[0] = resetFlagReg;
      `WCP_KICK_OFS:     rdValue = 32'h00000000;
      default:           addrOk = 1'b0;
    endcase
  end

  // one wait state: pready follows the first access cycle, for one cycle
  always @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h00000000;
    end
    else
    begin
      pready  <= psel && penable && !pready;
      pslverr <= psel && penable && !pready && !addrOk;
      if (rdStrobe)
        prdata <= rdValue;
    end
  end

endmodule // wcp_watchdog_ctrl
`default_nettype wire

// >>> pkg/wcp_defs.vh
// constants for the watchdog change-protection block
`ifndef WCP_DEFS_VH
`define WCP_DEFS_VH

// ----------------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------------
`define WCP_CTRL_OFS     12'h000
`define WCP_STAT_OFS     12'h004
`define WCP_IRQ_STAT_OFS 12'h008
`define WCP_IRQ_EN_OFS   12'h00c
`define WCP_IRQ_CLR_OFS  12'h010
`define WCP_FLAG_OFS     12'h014
`define WCP_KICK_OFS     12'h018

// ----------------------------------------------------------------------
// control register fields
// ----------------------------------------------------------------------
`define WCP_SEL0_BIT     0
`define WCP_SEL1_BIT     1
`define WCP_SEL2_BIT     2
`define WCP_EN_BIT       3
`define WCP_CHG_BIT      4
`define WCP_SEL3_BIT     5
`define WCP_IRQEN_BIT    6
`define WCP_TOIRQ_BIT    7

// ----------------------------------------------------------------------
// event bits (status, enable, clear)
// ----------------------------------------------------------------------
`define WCP_EV_TO_IRQ    0
`define WCP_EV_TO_RST    1
`define WCP_EV_REFUSED   2
`define WCP_EV_WIDTH     3

// ----------------------------------------------------------------------
// reset values and timing
// ----------------------------------------------------------------------
`define WCP_SEL_RST      4'h0
`define WCP_EV_RST       3'h0
`define WCP_WIN_CYCLES   3'h4
`define WCP_SEL_MAX      4'h9
`define WCP_BASE_TICKS   24'h000800
`define WCP_RST_PULSE    4'h8

`endif

// >>> verilog/wcp_timeout_counter.v
// watchdog timeout counter with selectable period
`timescale 1ns/1ps
`default_nettype none
`include "wcp_defs.vh"

module wcp_timeout_counter
(
  // clock and reset
  input  wire        ref_clk,
  input  wire        reset_n,
  // control
  input  wire        run,
  input  wire        kick,
  input  wire [3:0]  periodSel,
  input  wire        oscTick,
  // result
  output reg         expired
);

  reg  [23:0] countReg;
  reg  [23:0] limit;
  wire [3:0]  selUsed;

  // reserved codes fall back to the longest valid setting
  assign selUsed = (periodSel > `WCP_SEL_MAX) ? `WCP_SEL_MAX : periodSel;

  // limit is 2K oscillator ticks doubled per code step
  always @*
  begin
    limit = `WCP_BASE_TICKS << selUsed;
  end

  // count oscillator ticks while running; pulse on reaching the limit
  always @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      countReg <= 24'h000000;
      expired  <= 1'b0;
    end
    else
    begin
      expired <= 1'b0;
      if (!run || kick)
        countReg <= 24'h000000;
      else if (oscTick)
      begin
        if (countReg + 24'h000001 >= limit)
        begin
          countReg <= 24'h000000;
          expired  <= 1'b1;
        end
        else
          countReg <= countReg + 24'h000001;
      end
    end
  end

endmodule // wcp_timeout_counter
`default_nettype wire

// >>> sim/wcp_ctrl_chk.sv
// assertion checker for the watchdog control block
`timescale 1ns/1ps
`default_nettype none
module wcp_ctrl_chk
(
  // clock and reset
  input wire logic        ref_clk,
  input wire logic        reset_n,
  // apb side
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // watchdog side
  input wire logic        safetyLevel2,
  input wire logic        oscTick,
  input wire logic        watchdogReset,
  input wire logic        irq
);
  default clocking dc @(posedge ref_clk); endclocking
  default disable iff (!reset_n);
  // ----------------------------------------------------------------
  // decoded bus events
  // ----------------------------------------------------------------
  wire takeNow = psel && penable && !pready;
  wire mapped = paddr <= 12'h018 && paddr[1:0] == 2'b00;
  wire rdCtl = takeNow && !pwrite && paddr == 12'h000;
  wire openW = takeNow && pwrite && paddr == 12'h000 && pwdata[4:3] == 2'b11;
  // ----------------------------------------------------------------
  // properties
  // ----------------------------------------------------------------
  a_ready_one_wait: assert property (takeNow |=> pready)
    else $error("ready missing after access");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("ready longer than one cycle");
  a_ready_cause: assert property (pready |-> $past(takeNow))
    else $error("ready without access");
  a_err_with_ready: assert property (pslverr |-> pready)
    else $error("error without ready");
  a_unmapped_err: assert property (takeNow && !mapped |=> pslverr)
    else $error("unmapped access not refused");
  a_mapped_ok: assert property (takeNow && mapped |=> !pslverr)
    else $error("mapped access refused");
  a_err_reads_zero: assert property (pslverr && !pwrite |-> prdata == 32'h0)
    else $error("refused read not zero");
  a_level2_en_one: assert property (rdCtl && safetyLevel2 |=> prdata[3])
    else $error("enable reads zero at level 2");
  a_chg_closes: assert property (openW ##[5:12] rdCtl |=> !prdata[4])
    else $error("change bit still set after window");
  // ----------------------------------------------------------------
  // coverage
  // ----------------------------------------------------------------
  c_open: cover property (openW);
  c_err: cover property (pslverr);
  c_irq: cover property ($rose(irq));
endmodule // wcp_ctrl_chk
bind wcp_watchdog_ctrl wcp_ctrl_chk chk_u (.ref_clk, .reset_n, .psel, .penable, .pwrite,
  .paddr, .pwdata, .prdata, .pready, .pslverr, .safetyLevel2, .oscTick, .watchdogReset, .irq);
`default_nettype wire

// >>> sim/tb.sv
// self-checking bench for the watchdog control block
`timescale 1ns/1ps
`default_nettype none
`include "wcp_defs.vh"
module tb;
  logic        ref_clk = 1'b0;
  logic        reset_n = 1'b0;
  logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic        pready, pslverr, err, watchdogReset, irq;
  logic        safetyLevel2 = 1'b0, oscTick = 1'b0;
  integer      miscompares = 0, samples_checked = 0, cyc = 0, en, sel, rstSeen = 0;
  // clock and hang guard
  always #12.5 ref_clk = ~ref_clk;
  always @(posedge ref_clk)
  begin
    cyc <= cyc + 1;
    if (watchdogReset === 1'b1)
      rstSeen <= rstSeen + 1;
    if (cyc == 12000)
    begin
      miscompares++;
      print_verdict;
    end
  end
  wcp_watchdog_ctrl dut_u (.ref_clk, .reset_n, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .safetyLevel2, .oscTick, .watchdogReset, .irq);
  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] ctl(input integer e, input integer s);
    return (s & 7) | ((s >> 3) << 5) | (e << 3);
  endfunction
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // one apb transfer; keep holds psel for a back-to-back follower
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d, input bit keep);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    do
    begin
      @(posedge ref_clk);
    end
    while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    penable <= 1'b0;
    if (!keep)
    begin
      psel <= 1'b0;
      @(posedge ref_clk);
    end
  endtask
  task automatic do_reset(input logic lvl);
    reset_n <= 1'b0;
    safetyLevel2 <= lvl;
    repeat (12) @(posedge ref_clk);
    reset_n <= 1'b1;
    repeat (2) @(posedge ref_clk);
  endtask
  task automatic rd_ctl(input string nm);
    xfer(1'b0, `WCP_CTRL_OFS, 32'h0, 1'b0);
    chk(nm, rd, ctl(en, sel));
  endtask
  task automatic print_verdict;
    if (miscompares == 0 && samples_checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  // ----------------------------------------------------------------
  // level 1 sequences
  // ----------------------------------------------------------------
  initial
  begin
    void'($urandom(32'h214059c5));
    do_reset(1'b0);
    en = 0;
    sel = 0;
    rd_ctl("ctrl after reset");
    sel = $urandom_range(9);
    en = 1;
    xfer(1'b1, `WCP_CTRL_OFS, ctl(1, sel), 1'b0);
    rd_ctl("ctrl free enable");
    xfer(1'b1, `WCP_IRQ_EN_OFS, 32'h4, 1'b0);
    xfer(1'b1, `WCP_CTRL_OFS, ctl(0, sel), 1'b0);
    rd_ctl("ctrl plain clear");
    xfer(1'b0, `WCP_IRQ_STAT_OFS, 32'h0, 1'b0);
    chk("refused status", rd, 32'h4);
    chk("irq raised", irq, 1);
    xfer(1'b1, `WCP_IRQ_EN_OFS, 32'h0, 1'b0);
    repeat (2) @(posedge ref_clk);
    chk("irq masked", irq, 0);
    xfer(1'b1, `WCP_IRQ_CLR_OFS, 32'h4, 1'b0);
    xfer(1'b0, `WCP_IRQ_STAT_OFS, 32'h0, 1'b0);
    chk("status cleared", rd, 32'h0);
    // late close: window already shut
    xfer(1'b1, `WCP_CTRL_OFS, ctl(1, sel) | 32'h10, 1'b0);
    repeat (3) @(posedge ref_clk);
    xfer(1'b1, `WCP_CTRL_OFS, ctl(0, sel), 1'b0);
    rd_ctl("ctrl late close");
    xfer(1'b0, `WCP_IRQ_STAT_OFS, 32'h0, 1'b0);
    chk("late close refused", rd, 32'h4);
    xfer(1'b1, `WCP_IRQ_CLR_OFS, 32'h4, 1'b0);
    // timed unlock back to back
    sel = $urandom_range(9);
    en = 0;
    xfer(1'b1, `WCP_CTRL_OFS, ctl(1, sel) | 32'h10, 1'b1);
    xfer(1'b1, `WCP_CTRL_OFS, ctl(0, sel), 1'b0);
    repeat (6) @(posedge ref_clk);
    rd_ctl("ctrl unlocked clear");
    // stopped, then interrupt-only timeout at the shortest code
    xfer(1'b1, `WCP_CTRL_OFS, 32'h0, 1'b0);
    xfer(1'b1, `WCP_IRQ_EN_OFS, 32'h1, 1'b0);
    oscTick <= 1'b1;
    repeat (3000) @(posedge ref_clk);
    xfer(1'b0, `WCP_IRQ_STAT_OFS, 32'h0, 1'b0);
    chk("stopped status", rd, 32'h0);
    xfer(1'b1, `WCP_CTRL_OFS, 32'h40, 1'b0);
    repeat (1990) @(posedge ref_clk);
    xfer(1'b0, `WCP_IRQ_STAT_OFS, 32'h0, 1'b0);
    chk("early timeout", rd, 32'h0);
    repeat (100) @(posedge ref_clk);
    xfer(1'b0, `WCP_IRQ_STAT_OFS, 32'h0, 1'b0);
    chk("timeout status", rd, 32'h1);
    chk("timeout irq", irq, 1);
    chk("no reset", watchdogReset, 0);
    oscTick <= 1'b0;
    // reset-only timeout; its flag then holds enable on
    xfer(1'b1, `WCP_CTRL_OFS, ctl(1, 0) | 32'h80, 1'b0);
    xfer(1'b1, `WCP_KICK_OFS, 32'h0, 1'b0);
    xfer(1'b1, `WCP_IRQ_CLR_OFS, 32'h7, 1'b0);
    oscTick <= 1'b1;
    repeat (2100) @(posedge ref_clk);
    oscTick <= 1'b0;
    xfer(1'b0, `WCP_STAT_OFS, 32'h0, 1'b0);
    chk("status after reset", rd, 32'h3);
    xfer(1'b0, `WCP_IRQ_STAT_OFS, 32'h0, 1'b0);
    chk("reset event", rd, 32'h2);
    chk("reset pulse", rstSeen, `WCP_RST_PULSE);
    en = 1;
    sel = 0;
    xfer(1'b1, `WCP_CTRL_OFS, ctl(1, 0) | 32'h10, 1'b1);
    xfer(1'b1, `WCP_CTRL_OFS, ctl(0, 0), 1'b0);
    rd_ctl("ctrl flag holds enable");
    xfer(1'b1, `WCP_FLAG_OFS, 32'h0, 1'b0);
    en = 0;
    rd_ctl("ctrl flag cleared");
    // ----------------------------------------------------------------
    // level 2 sequences
    // ----------------------------------------------------------------
    do_reset(1'b1);
    en = 1;
    sel = 0;
    rd_ctl("ctrl level2");
    xfer(1'b1, `WCP_CTRL_OFS, ctl(0, 3), 1'b0);
    rd_ctl("ctrl plain period");
    xfer(1'b0, `WCP_IRQ_STAT_OFS, 32'h0, 1'b0);
    chk("level2 refused", rd, 32'h4);
    sel = $urandom_range(9, 1);
    xfer(1'b1, `WCP_CTRL_OFS, 32'h18, 1'b1);
    xfer(1'b1, `WCP_CTRL_OFS, ctl(0, sel), 1'b0);
    repeat (6) @(posedge ref_clk);
    rd_ctl("ctrl new period");
    xfer(1'b0, 12'h01c, 32'h0, 1'b0);
    chk("unmapped error", err, 1);
    chk("unmapped data", rd, 32'h0);
    print_verdict;
  end
endmodule // tb
`default_nettype wire
